// [hw/ucnt_pkg.sv]
// Constants shared by the up/down reload counter design.
package ucnt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [15:0] UCNT_CTRL_IDX  = 16'hffc3;
    localparam logic [15:0] UCNT_MODE_IDX  = 16'hffc4;
    localparam logic [15:0] UCNT_COUNT_IDX = 16'hffc5;

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] UCNT_MODE_RST   = 8'h18;
    localparam logic [7:0] UCNT_COUNT_RST  = 8'h00;
    localparam logic [7:0] UCNT_RELOAD_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Mode register fields.
    localparam int          UCNT_AR_BIT     = 7;
    localparam int          UCNT_DSRC_BIT   = 6;
    localparam int          UCNT_SDIR_BIT   = 5;
    localparam int          UCNT_CS_LSB     = 0;
    localparam logic [7:0]  UCNT_MODE_RSVD  = 8'h18;
    localparam logic [2:0]  UCNT_CS_EXT     = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields.
    localparam int UCNT_FLAG_BIT = 0;
    localparam int UCNT_IEN_BIT  = 1;
    localparam int UCNT_EDGE_BIT = 2;

    ////////////////////////////////////////////////////////////////////////
    // Counter limits and prescaler taps (log2 of each divisor).
    localparam logic [7:0] UCNT_CNT_MAX = 8'hff;
    localparam logic [7:0] UCNT_CNT_MIN = 8'h00;
    localparam int         UCNT_PS_W    = 13;
    localparam int         UCNT_NDIV    = 7;
    localparam int         UCNT_DIV_LOG2 [UCNT_NDIV] = '{13, 11, 9, 8, 7, 5, 3};

endpackage : ucnt_pkg

// [hw/ucnt_prescaler.sv]
// Free-running prescaler giving one-cycle ticks at the seven divided rates.
`timescale 1ns/100ps
module ucnt_prescaler (
    input  wire logic                         clk_i,
    input  wire logic                         resetn_i,
    output logic [ucnt_pkg::UCNT_NDIV-1:0]    tick_o
);

    logic [ucnt_pkg::UCNT_PS_W-1:0] ps;
    logic [ucnt_pkg::UCNT_NDIV-1:0] next_tick;

    function automatic logic [ucnt_pkg::UCNT_PS_W-1:0] ucnt_mask(input int sh);
        ucnt_mask = ucnt_pkg::UCNT_PS_W'((64'd1 << sh) - 64'd1);
    endfunction : ucnt_mask

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ps <= '0;
        end else begin
            ps <= ps + 1'b1;
        end
    end

    always_comb begin
        for (int k = 0; k < ucnt_pkg::UCNT_NDIV; k++) begin
            next_tick[k] = (ps & ucnt_mask(ucnt_pkg::UCNT_DIV_LOG2[k]))
                           == ucnt_mask(ucnt_pkg::UCNT_DIV_LOG2[k]);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_o <= '0;
        end else begin
            tick_o <= next_tick;
        end
    end

endmodule : ucnt_prescaler

// [hw/ucnt_pin_sync.sv]
// Three-stage pin synchroniser with a filtered level and edge pulses.
`timescale 1ns/100ps
module ucnt_pin_sync (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic s1;
    logic s2;
    logic s3;
    logic agree;

    // A change counts only once the second and third stages agree.
    assign agree = (s2 == s3);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1      <= 1'b0;
            s2      <= 1'b0;
            s3      <= 1'b0;
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            s1      <= pin_i;
            s2      <= s1;
            s3      <= s2;
            level_o <= agree ? s3 : level_o;
            rise_o  <= agree & s3 & ~level_o;
            fall_o  <= agree & ~s3 & level_o;
        end
    end

endmodule : ucnt_pin_sync

// [hw/ucnt_top.sv]
// Eight-bit up/down interval and auto-reload counter with an APB slave.
//
// Contract
// - Reload select 0 runs the counter as a free 8-bit interval timer.
// - Reset gives count 00 and mode 18; counting starts at once.
// - Clock select picks one of seven prescaler taps or the event pin.
// - Direction source picks software direction bit or direction pin.
// - Counting past FF up or 00 down sets the timer request flag.
// - Interrupt request is raised while flag and enable are both set.
// - Interval mode wraps to 00 on overflow, FF on underflow.
// - Interval mode: a reload write also loads the counter.
// - Reload select 1: each reload write loads the counter too.
// - Auto-reload mode loads the reload value on overflow or underflow.
// - Auto-reload period is 1 to 256 counting clocks via reload value.
// - Clock select code 111 selects the external event pin.
// - External clocking counts on the configured pin edge.
// - Pin control: direction pin high counts down, low counts up.
// - Codes 000 to 110 map to divide by 8192 down to divide by 8.
// - Software direction bit 0 counts up, 1 counts down.
// - Shared address: reads give the counter, writes go to reload.
// - A separate edge select bit picks the event pin edge.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module ucnt_top (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic        event_clock_pin_i,
    input  wire logic        direction_pin_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // State and wiring.
    logic                           autoreload_select;
    logic                           direction_source_select;
    logic                           soft_direction;
    logic [2:0]                     clock_select;
    logic [7:0]                     count_value;
    logic [7:0]                     reload_value;
    logic                           timer_irq_flag;
    logic                           timer_irq_enable;
    logic                           event_edge_select;
    logic [ucnt_pkg::UCNT_NDIV-1:0] div_tick;
    logic                           ev_rise;
    logic                           ev_fall;
    logic                           dir_level;
    logic                           setup;
    logic                           access;
    logic                           wr_mode;
    logic                           wr_ctrl;
    logic                           ld_wr;
    logic                           hit;
    logic                           cnt_en;
    logic                           down;
    logic                           terminal;
    logic [7:0]                     next_count;
    logic [7:0]                     mode_rd;
    logic [31:0]                    next_rdata;

    function automatic logic [31:0] ucnt_addr(input logic [15:0] idx);
        ucnt_addr = {14'h0000, idx, 2'b00};
    endfunction : ucnt_addr

    function automatic logic ucnt_is(input logic [31:0] a,
                                     input logic [15:0] idx);
        ucnt_is = (a == ucnt_addr(idx));
    endfunction : ucnt_is

    ////////////////////////////////////////////////////////////////////////
    // Clock sources and pins.
    ucnt_prescaler u_prescaler (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .tick_o   (div_tick)
    );

    ucnt_pin_sync u_event_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin_i    (event_clock_pin_i),
        .level_o  (),
        .rise_o   (ev_rise),
        .fall_o   (ev_fall)
    );

    ucnt_pin_sync u_dir_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin_i    (direction_pin_i),
        .level_o  (dir_level),
        .rise_o   (),
        .fall_o   ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode. The slave answers in the first access cycle.
    always_comb begin
        setup   = psel_i & ~penable_i;
        access  = psel_i & penable_i & pready_o;
        hit     = ucnt_is(paddr_i, ucnt_pkg::UCNT_MODE_IDX)
                | ucnt_is(paddr_i, ucnt_pkg::UCNT_COUNT_IDX)
                | ucnt_is(paddr_i, ucnt_pkg::UCNT_CTRL_IDX);
        wr_mode = access & pwrite_i
                & ucnt_is(paddr_i, ucnt_pkg::UCNT_MODE_IDX);
        wr_ctrl = access & pwrite_i
                & ucnt_is(paddr_i, ucnt_pkg::UCNT_CTRL_IDX);
        ld_wr   = access & pwrite_i
                & ucnt_is(paddr_i, ucnt_pkg::UCNT_COUNT_IDX);
    end

    always_comb begin
        mode_rd = ucnt_pkg::UCNT_MODE_RSVD;
        mode_rd[ucnt_pkg::UCNT_AR_BIT]   = autoreload_select;
        mode_rd[ucnt_pkg::UCNT_DSRC_BIT] = direction_source_select;
        mode_rd[ucnt_pkg::UCNT_SDIR_BIT] = soft_direction;
        mode_rd[ucnt_pkg::UCNT_CS_LSB +: 3] = clock_select;
        next_rdata = 32'h0000_0000;
        if (ucnt_is(paddr_i, ucnt_pkg::UCNT_MODE_IDX)) begin
            next_rdata[7:0] = mode_rd;
        end else if (ucnt_is(paddr_i, ucnt_pkg::UCNT_COUNT_IDX)) begin
            next_rdata[7:0] = count_value;
        end else if (ucnt_is(paddr_i, ucnt_pkg::UCNT_CTRL_IDX)) begin
            next_rdata[ucnt_pkg::UCNT_FLAG_BIT] = timer_irq_flag;
            next_rdata[ucnt_pkg::UCNT_IEN_BIT]  = timer_irq_enable;
            next_rdata[ucnt_pkg::UCNT_EDGE_BIT] = event_edge_select;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~hit;
            if (setup && !pwrite_i) begin
                prdata_o <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode and control registers.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            autoreload_select       <= ucnt_pkg::UCNT_MODE_RST[7];
            direction_source_select <= ucnt_pkg::UCNT_MODE_RST[6];
            soft_direction          <= ucnt_pkg::UCNT_MODE_RST[5];
            clock_select            <= ucnt_pkg::UCNT_MODE_RST[2:0];
        end else if (wr_mode) begin
            autoreload_select       <= pwdata_i[ucnt_pkg::UCNT_AR_BIT];
            direction_source_select <= pwdata_i[ucnt_pkg::UCNT_DSRC_BIT];
            soft_direction          <= pwdata_i[ucnt_pkg::UCNT_SDIR_BIT];
            clock_select            <= pwdata_i[ucnt_pkg::UCNT_CS_LSB +: 3];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer_irq_enable  <= 1'b0;
            event_edge_select <= 1'b0;
        end else if (wr_ctrl) begin
            timer_irq_enable  <= pwdata_i[ucnt_pkg::UCNT_IEN_BIT];
            event_edge_select <= pwdata_i[ucnt_pkg::UCNT_EDGE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counting clock and direction.
    always_comb begin
        cnt_en = 1'b0;
        unique case (clock_select)
            3'h0: cnt_en = div_tick[0];
            3'h1: cnt_en = div_tick[1];
            3'h2: cnt_en = div_tick[2];
            3'h3: cnt_en = div_tick[3];
            3'h4: cnt_en = div_tick[4];
            3'h5: cnt_en = div_tick[5];
            3'h6: cnt_en = div_tick[6];
            3'h7: cnt_en = event_edge_select ? ev_rise : ev_fall;
        endcase
    end

    assign down = direction_source_select ? dir_level : soft_direction;

    assign terminal = cnt_en & ~ld_wr
                    & (down ? (count_value == ucnt_pkg::UCNT_CNT_MIN)
                            : (count_value == ucnt_pkg::UCNT_CNT_MAX));

    always_comb begin
        next_count = count_value;
        if (ld_wr) begin
            next_count = pwdata_i[7:0];
        end else if (terminal) begin
            if (autoreload_select) begin
                next_count = reload_value;
            end else begin
                next_count = down ? ucnt_pkg::UCNT_CNT_MAX
                                  : ucnt_pkg::UCNT_CNT_MIN;
            end
        end else if (cnt_en) begin
            next_count = down ? count_value - 8'h01 : count_value + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, reload and request flag.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_value <= ucnt_pkg::UCNT_COUNT_RST;
        end else begin
            count_value <= next_count;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reload_value <= ucnt_pkg::UCNT_RELOAD_RST;
        end else if (ld_wr) begin
            reload_value <= pwdata_i[7:0];
        end
    end

    // A wrap in the same cycle as a software clear keeps the flag set.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer_irq_flag <= 1'b0;
        end else if (terminal) begin
            timer_irq_flag <= 1'b1;
        end else if (wr_ctrl && !pwdata_i[ucnt_pkg::UCNT_FLAG_BIT]) begin
            timer_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= timer_irq_flag & timer_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_load;
        ld_wr;
    endsequence

    sequence s_step_up;
        cnt_en && !ld_wr && !down && !terminal;
    endsequence

    sequence s_step_down;
        cnt_en && !ld_wr && down && !terminal;
    endsequence

    a_step_up_count : assert property (
        s_step_up |=> count_value == $past(count_value) + 8'h01)
        else $error("Up step did not add one.");

    a_idle_hold : assert property (
        !cnt_en && !ld_wr |=> $stable(count_value))
        else $error("Counter moved without a counting clock.");

    a_flag_on_wrap : assert property (
        terminal |=> timer_irq_flag)
        else $error("Wrap did not set the request flag.");

    a_irq_follows : assert property (
        timer_irq_flag && timer_irq_enable |=> irq_o)
        else $error("Request not raised for enabled flag.");

    a_irq_masked : assert property (
        !timer_irq_enable |=> !irq_o)
        else $error("Request raised while disabled.");

    a_interval_wrap : assert property (
        terminal && !autoreload_select
        |=> count_value == ($past(down) ? 8'hff : 8'h00))
        else $error("Interval wrap value wrong.");

    a_load_counter : assert property (
        s_load |=> count_value == $past(pwdata_i[7:0])
                   && reload_value == $past(pwdata_i[7:0]))
        else $error("Reload write did not load counter.");

    a_reload_wrap : assert property (
        terminal && autoreload_select
        |=> count_value == $past(reload_value))
        else $error("Auto-reload did not load reload value.");

    a_ext_edge : assert property (
        clock_select == 3'h7 && !ld_wr
        && (event_edge_select ? ev_rise : ev_fall)
        |=> count_value != $past(count_value)
            || $past(terminal && autoreload_select))
        else $error("External edge did not step counter.");

    a_pin_down : assert property (
        direction_source_select && dir_level ##0 s_step_down
        |=> count_value == $past(count_value) - 8'h01)
        else $error("Direction pin high did not count down.");

    a_soft_up : assert property (
        !direction_source_select && !soft_direction && cnt_en
        && !ld_wr && count_value == 8'h10 |=> count_value == 8'h11)
        else $error("Soft direction zero did not count up.");

    a_pready_pulse : assert property (
        pready_o |=> !pready_o)
        else $error("Ready held longer than one cycle.");

endmodule : ucnt_top

// [tb/ucnt_pin_model.sv]
// Behavioural model of the event and direction pins at the far side.
`timescale 1ns/100ps
module ucnt_pin_model (
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic [8:0] count_i,
    input  wire logic       dir_i,
    output logic            event_clock_pin_o,
    output logic            direction_pin_o,
    output logic            busy_o
);
    logic [12:0] phase;

    initial begin
        event_clock_pin_o = 1'b0;
        direction_pin_o   = 1'b0;
        busy_o            = 1'b0;
        phase             = 13'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction pin enabled.
    always @(posedge clk_i) begin
        direction_pin_o <= dir_i;
    end

    // Event pin enabled.
    // Each level holds eight cycles, well above the synchroniser minimum.
    always @(posedge clk_i) begin
        if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            phase  <= {count_i, 4'h0};
        end else if (busy_o) begin
            if (phase == 13'h0000) begin
                busy_o <= 1'b0;
            end else begin
                phase <= phase - 13'h0001;
            end
            event_clock_pin_o <= (phase != 13'h0000) && phase[3];
        end
    end
endmodule : ucnt_pin_model

// [tb/updown_reload_counter8_test.sv]
// Self-checking testbench for the up/down reload counter.
`timescale 1ns/100ps
module updown_reload_counter8_test;
    logic        clk_i     = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [31:0] paddr_i   = 32'h0;
    logic [31:0] pwdata_i  = 32'h0;
    logic        start     = 1'b0;
    logic        dir_req   = 1'b0;
    logic [8:0]  npulse    = 9'h000;
    logic        ev_pin;
    logic        dir_pin;
    logic        busy;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        irq_o;
    int          err_count   = 0;
    int          check_count = 0;
    localparam logic [31:0] A_CTRL = {14'h0, ucnt_pkg::UCNT_CTRL_IDX, 2'b00};
    localparam logic [31:0] A_MODE = {14'h0, ucnt_pkg::UCNT_MODE_IDX, 2'b00};
    localparam logic [31:0] A_CNT  = {14'h0, ucnt_pkg::UCNT_COUNT_IDX, 2'b00};

    always #5 clk_i = ~clk_i;

    ucnt_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .event_clock_pin_i(ev_pin),
        .direction_pin_i(dir_pin), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));

    ucnt_pin_model PEER (.clk_i(clk_i), .start_i(start), .count_i(npulse),
        .dir_i(dir_req), .event_clock_pin_o(ev_pin),
        .direction_pin_o(dir_pin), .busy_o(busy));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // The answer is taken at the rising edge that samples pready high.
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int   n;
        logic got;
        n = 0;
        got = 1'b0;
        q = 32'h0;
        e = 1'b0;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (pready_o === 1'b1) begin
                got = 1'b1;
                q = prdata_o;
                e = pslverr_o;
            end
        end while (!got && n < 40);
        if (!got) err_count++;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {24'h0, d}, q, e);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd

    task automatic pulses(input int n);
        int t;
        t = 0;
        @(posedge clk_i);
        npulse <= n[8:0];
        start  <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        do begin
            @(negedge clk_i);
            t++;
        end while (busy !== 1'b0 && t < 9000);
        if (busy !== 1'b0) err_count++;
        repeat (6) @(posedge clk_i);
    endtask : pulses

    function automatic logic [8:0] predict(input logic [7:0] rl, input int n,
                                           input logic up, input logic ar);
        logic [7:0] c;
        logic       f;
        c = rl;
        f = 1'b0;
        for (int i = 0; i < n; i++) begin
            if ((up && c == 8'hff) || (!up && c == 8'h00)) begin
                f = 1'b1;
                c = ar ? rl : (up ? 8'h00 : 8'hff);
            end else begin
                c = up ? c + 8'h01 : c - 8'h01;
            end
        end
        return {f, c};
    endfunction : predict

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (80000) @(posedge clk_i);
        err_count++;
        stop_test();
    end

    initial begin
        logic [31:0] q;
        logic [31:0] r;
        logic        e;
        logic [8:0]  p;
        logic        ar, dsrc, sdir, up, ien, edg;
        logic [7:0]  rl;
        int          n;
        r = $urandom(32'h2576);
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(A_MODE, q);
        chk("mode reset", q, 32'h18);
        rd(A_CNT, q);
        chk("count reset", q, 32'h00);
        apb(1'b0, 32'h0003ff00, 32'h0, q, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        for (int c = 0; c < 7; c++) begin
            wr(A_MODE, {5'h00, c[2:0]});
            wr(A_CNT, 8'h00);
            repeat (4 << ucnt_pkg::UCNT_DIV_LOG2[c]) @(posedge clk_i);
            rd(A_CNT, q);
            chk("tap rate", {31'h0, q >= 3 && q <= 5}, 32'h1);
            rd(A_MODE, q);
            chk("mode read", q, {27'h03, c[2:0]});
        end
        for (int i = 0; i < 14; i++) begin
            r = $urandom;
            ar = r[0];
            dsrc = r[1];
            sdir = r[2];
            edg = r[4];
            ien = r[5];
            rl = r[15:8];
            n = 1 + int'(r[20:16]);
            if (i < 2) begin
                ar = ~i[0];
                dsrc = 1'b0;
                sdir = i[0];
                rl = {8{~i[0]}};
                n = 3 - 2 * i;
            end else if (i == 2) begin
                dsrc = 1'b0;
                sdir = 1'b0;
                rl = 8'h0e;
                n = 5;
            end else if (r[6]) begin
                rl = r[7] ? 8'hf8 : 8'h04;
            end
            up = dsrc ? ~r[3] : ~sdir;
            dir_req <= r[3];
            wr(A_CTRL, {5'h00, edg, ien, 1'b0});
            wr(A_MODE, {ar, dsrc, sdir, 5'h1f});
            wr(A_CNT, rl);
            pulses(n);
            p = predict(rl, n, up, ar);
            rd(A_CNT, q);
            chk("count", q, {24'h0, p[7:0]});
            rd(A_CTRL, q);
            chk("flag", q, {29'h0, edg, ien, p[8]});
            chk("irq", {31'h0, irq_o}, {31'h0, p[8] & ien});
        end
        stop_test();
    end
endmodule : updown_reload_counter8_test
